/* dat_pkg.sv */
// Constants for the debug arm, trigger and status slice
//
// Functional notes
// - Armed: only arm, trigger, bank select writable
// - Bank select maps comparator window 0x28-0x2F
// - Bank select picks register at 0x27
// - Control readable; bits 4:3 writable when disarmed
// - Disarm write leaves bits 4:3 unchanged
// - Arm cleared by software, completion, untraced breakpoint
// - Arming enters state1, flags forced 001
// - Trigger write one triggers now; reads zero
// - Without trigger bit, wait for final state
// - Trace request clear: trigger starts no tracing
// - Begin-aligned tracing ignores later trigger writes
// - Secured chip: no tracing, trigger starts none
// - Arm and trigger together end session while armed; while disarmed they arm, then trigger
// - Breakpoint routes to background or software interrupt
// - Final state requests breakpoint, after trace if tracing
// - Status register read-only
// - Full flag after 64 lines since arming
// - Full cleared by arm write, power-on only
// - State flags encode sequencer state, 101-111 reserved
// - Flags track transitions; hold on software disarm
// - Internal end returns flags to 000
// - Secured: breakpoints still work, tracing impossible

package dat_pkg;

    // --------------------
    // Register offsets
    // --------------------
    localparam logic [7:0] OFS_CONTROL_ONE = 8'h20;
    localparam logic [7:0] OFS_STATUS      = 8'h21;
    localparam logic [7:0] OFS_LINE_COUNT  = 8'h26;
    localparam logic [7:0] OFS_SEQ_WINDOW  = 8'h27;
    localparam logic [7:0] OFS_COMP_FIRST  = 8'h28;
    localparam logic [7:0] OFS_COMP_LAST   = 8'h2F;

    // --------------------
    // Field positions
    // --------------------
    localparam int BIT_ARM       = 7;
    localparam int BIT_TRIGGER   = 6;
    localparam int BIT_BG_ROUTE  = 4;
    localparam int BIT_BRK_EN    = 3;
    localparam int BIT_FULL      = 7;

    // --------------------
    // Reset values and codes
    // --------------------
    localparam logic [1:0] BANK_NONE       = 2'h3;
    localparam logic [2:0] SSF_STATE0      = 3'h0;
    localparam logic [2:0] SSF_STATE1      = 3'h1;
    localparam logic [2:0] SSF_FINAL       = 3'h4;
    localparam logic [7:0] FULL_LINES      = 8'h40;
    localparam logic [7:0] READ_ZERO       = 8'h00;

endpackage

/* dat_break_route.sv */
// Breakpoint routing to background debug or software interrupt
`timescale 1ns/100ps
`default_nettype none

module dat_break_route (
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // Request and routing controls
    input  wire logic brk_req,
    input  wire logic background_debug_route,
    input  wire logic background_enable_bit,
    input  wire logic background_active,
    // Breakpoint pulses
    output var  logic brk_background,
    output var  logic brk_software_interrupt
);

    // --------------------
    // Route decode
    // --------------------
    wire to_bg;
    wire to_swi;

    assign to_bg  = background_debug_route & background_enable_bit;
    assign to_swi = background_debug_route ? ~background_enable_bit
                                           : ~background_active;

    // At most one pulse per request; none while background is active with the background route bit clear
    always_ff @(posedge clk) begin
        if (reset) begin
            brk_background         <= 1'b0;
            brk_software_interrupt <= 1'b0;
        end else begin
            brk_background         <= brk_req & to_bg;
            brk_software_interrupt <= brk_req & to_swi;
        end
    end

endmodule // dat_break_route

`default_nettype wire

/* dat_debug_ctrl.sv */
// Debug unit arm, trigger, breakpoint and status control slice
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none

module dat_debug_ctrl (
    // Clock and resets
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       por,
    // Register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    output var  logic [7:0] reg_rdata,
    // Comparator bank window
    output logic      [1:0] comparator_bank_select,
    output logic      [2:0] comp_write,
    output logic      [2:0] comp_offset,
    output logic      [7:0] comp_wdata,
    input  wire logic [7:0] comp_rdata_a,
    input  wire logic [7:0] comp_rdata_b,
    input  wire logic [7:0] comp_rdata_c,
    // Sequencer control registers and match flags
    output logic      [2:0] seq_ctrl_write,
    input  wire logic [3:0] seq_ctrl_reg_first,
    input  wire logic [3:0] seq_ctrl_reg_second,
    input  wire logic [3:0] seq_ctrl_reg_third,
    input  wire logic [2:0] match_flag_reg,
    // State sequencer
    input  wire logic       seq_step,
    input  wire logic [2:0] seq_state,
    output var  logic       seq_enter_state1,
    output var  logic       seq_return_state0,
    // Trace control and buffer
    input  wire logic       trace_request,
    input  wire logic       trigger_alignment,
    input  wire logic       tracing_active,
    input  wire logic       trace_session_done,
    input  wire logic       trace_line_stored,
    input  wire logic [5:0] trace_line_count,
    output var  logic       trace_trigger,
    output logic            trace_enable,
    output logic            trace_all_valid,
    // Background debug and security
    input  wire logic       background_enable_bit,
    input  wire logic       background_active,
    input  wire logic       chip_secured,
    output logic            brk_background,
    output logic            brk_software_interrupt,
    // Status
    output logic            armed
);

    // --------------------
    // State
    // --------------------
    logic       arm;
    logic       background_debug_route;
    logic       breakpoint_request_en;
    logic [1:0] bank_sel;
    logic [2:0] sequencer_state_flags;
    logic       trace_full_flag;
    logic [6:0] lines_since_arm;
    logic       triggered;
    logic       brk_pending;
    logic       brk_req;
    logic       arm_force_trigger_pending;

    // --------------------
    // Address decode
    // --------------------
    wire hit_ctrl;
    wire hit_status;
    wire hit_count;
    wire hit_seqwin;
    wire hit_compwin;

    assign hit_ctrl    = reg_addr == dat_pkg::OFS_CONTROL_ONE;
    assign hit_status  = reg_addr == dat_pkg::OFS_STATUS;
    assign hit_count   = reg_addr == dat_pkg::OFS_LINE_COUNT;
    assign hit_seqwin  = reg_addr == dat_pkg::OFS_SEQ_WINDOW;
    assign hit_compwin = (reg_addr >= dat_pkg::OFS_COMP_FIRST) &&
                         (reg_addr <= dat_pkg::OFS_COMP_LAST);

    // --------------------
    // Control register write decode
    // --------------------
    wire ctrl_wr;
    wire wr_arm;
    wire wr_force_trigger;
    wire end_by_sw;
    wire arming;
    wire disarm_by_sw;

    assign ctrl_wr      = reg_write & hit_ctrl;
    assign wr_arm       = reg_wdata[dat_pkg::BIT_ARM];
    assign wr_force_trigger      = reg_wdata[dat_pkg::BIT_TRIGGER];
    // Arm and trigger written together while armed end the session
    assign end_by_sw    = ctrl_wr & arm & wr_arm & wr_force_trigger;
    assign arming       = ctrl_wr & ~arm & wr_arm;
    assign disarm_by_sw = end_by_sw | (ctrl_wr & arm & ~wr_arm);

    // --------------------
    // Trigger logic
    // --------------------
    wire trace_ok;
    wire force_force_trigger;
    wire final_reached;
    wire force_trigger_now;
    wire force_trigger_traced;

    // A secured chip never traces, breakpoints still run
    assign trace_ok      = trace_request & ~chip_secured;
    // Begin-aligned tracing already running ignores the trigger bit
    assign force_force_trigger    = ctrl_wr & wr_force_trigger & ~wr_arm & arm
                           & ~(tracing_active & trigger_alignment)
                         | arm & arm_force_trigger_pending;
    assign final_reached = seq_step & (seq_state == dat_pkg::SSF_FINAL);
    assign force_trigger_now      = ~triggered & ~end_by_sw
                         & ((arm & final_reached) | force_force_trigger);
    assign force_trigger_traced   = force_trigger_now & trace_ok;

    // --------------------
    // Session end and breakpoint requests
    // --------------------
    wire brk_untraced;
    wire brk_after_trace;
    wire session_done;
    wire end_internal;

    // Untraced trigger: breakpoint at once
    assign brk_untraced    = force_trigger_now & ~trace_ok & breakpoint_request_en;
    // Traced session: breakpoint when the trace completes
    assign brk_after_trace = arm & triggered & trace_session_done
                           & brk_pending;
    assign session_done    = arm & triggered & trace_session_done;
    assign end_internal    = ~disarm_by_sw & ~arming
                           & (session_done | (force_trigger_now & ~trace_ok));

    // --------------------
    // Arm bit and bank selector
    // --------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            arm      <= 1'b0;
            bank_sel <= 2'h0;
        end else begin
            if (ctrl_wr) begin
                bank_sel <= reg_wdata[1:0];
            end
            if (arming) begin
                arm <= 1'b1;
            end else if (disarm_by_sw | end_internal) begin
                arm <= 1'b0;
            end
        end
    end

    // --------------------
    // Locked control bits
    // --------------------
    // Arm is sampled before the write, so a disarming write keeps them
    always_ff @(posedge clk) begin
        if (reset) begin
            background_debug_route <= 1'b0;
            breakpoint_request_en  <= 1'b0;
        end else if (ctrl_wr & ~arm) begin
            background_debug_route <= reg_wdata[dat_pkg::BIT_BG_ROUTE];
            breakpoint_request_en  <= reg_wdata[dat_pkg::BIT_BRK_EN];
        end
    end

    // --------------------
    // Deferred trigger of an arming write
    // --------------------
    // Arm and trigger in one write while disarmed: trigger once armed
    always_ff @(posedge clk) begin
        if (reset) begin
            arm_force_trigger_pending <= 1'b0;
        end else begin
            arm_force_trigger_pending <= arming & wr_force_trigger;
        end
    end

    // --------------------
    // Trigger and pending breakpoint tracking
    // --------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            triggered     <= 1'b0;
            brk_pending   <= 1'b0;
            trace_trigger <= 1'b0;
            brk_req       <= 1'b0;
        end else begin
            trace_trigger <= force_trigger_traced;
            brk_req       <= brk_untraced | brk_after_trace;
            if (arming | disarm_by_sw | end_internal) begin
                triggered   <= 1'b0;
                brk_pending <= 1'b0;
            end else if (force_trigger_now) begin
                triggered   <= 1'b1;
                brk_pending <= breakpoint_request_en & trace_ok;
            end
        end
    end

    // --------------------
    // Sequencer control pulses and state flags
    // --------------------
    wire step_valid;

    // Reserved codes from the sequencer are not reported
    assign step_valid = arm & seq_step & (seq_state <= dat_pkg::SSF_FINAL);

    always_ff @(posedge clk) begin
        if (reset) begin
            seq_enter_state1      <= 1'b0;
            seq_return_state0     <= 1'b0;
            sequencer_state_flags <= dat_pkg::SSF_STATE0;
        end else begin
            seq_enter_state1  <= arming;
            seq_return_state0 <= end_internal;
            if (arming) begin
                sequencer_state_flags <= dat_pkg::SSF_STATE1;
            end else if (end_internal) begin
                sequencer_state_flags <= dat_pkg::SSF_STATE0;
            end else if (step_valid & ~disarm_by_sw) begin
                sequencer_state_flags <= seq_state;
            end
        end
    end

    // --------------------
    // Trace-full flag
    // --------------------
    wire [6:0] next_lines;
    wire       full_set;
    wire       full_clr;

    assign next_lines = lines_since_arm + 7'h01;
    assign full_set   = trace_line_stored & (next_lines >= dat_pkg::FULL_LINES[6:0]);
    assign full_clr   = ctrl_wr & wr_arm;

    // Counter restarts on arming and saturates once full
    always_ff @(posedge clk) begin
        if (reset) begin
            lines_since_arm <= 7'h00;
        end else if (arming) begin
            lines_since_arm <= 7'h00;
        end else if (trace_line_stored & ~lines_since_arm[6]) begin
            lines_since_arm <= next_lines;
        end
    end

    // Power-on and any write with the arm bit set clear it; a line stored with the count at 63 or above wins over the clear
    always_ff @(posedge clk) begin
        if (por) begin
            trace_full_flag <= 1'b0;
        end else if (full_set) begin
            trace_full_flag <= 1'b1;
        end else if (full_clr) begin
            trace_full_flag <= 1'b0;
        end
    end

    // --------------------
    // Window write routing
    // --------------------
    wire       win_wr_ok;
    wire [2:0] bank_onehot;

    // All other register bits are locked while armed
    assign win_wr_ok   = reg_write & ~arm;
    assign bank_onehot = (bank_sel == 2'h0) ? 3'b001 :
                         (bank_sel == 2'h1) ? 3'b010 :
                         (bank_sel == 2'h2) ? 3'b100 : 3'b000;

    assign comp_write     = (win_wr_ok & hit_compwin) ? bank_onehot : 3'b000;
    assign comp_offset    = reg_addr[2:0];
    assign comp_wdata     = reg_wdata;
    assign seq_ctrl_write = (win_wr_ok & hit_seqwin) ? bank_onehot : 3'b000;

    // --------------------
    // Read data selection
    // --------------------
    wire [7:0] ctrl_view;
    wire [7:0] status_view;
    wire [7:0] count_view;
    wire [7:0] seqwin_view;
    wire [7:0] compwin_view;
    wire [7:0] read_mux;

    // Trigger bit always reads zero
    assign ctrl_view    = {arm, 1'b0, 1'b0, background_debug_route,
                           breakpoint_request_en, 1'b0, bank_sel};
    assign status_view  = {trace_full_flag, 4'h0, sequencer_state_flags};
    assign count_view   = {trace_full_flag, 1'b0, trace_line_count};
    assign seqwin_view  = (bank_sel == 2'h0) ? {4'h0, seq_ctrl_reg_first}  :
                          (bank_sel == 2'h1) ? {4'h0, seq_ctrl_reg_second} :
                          (bank_sel == 2'h2) ? {4'h0, seq_ctrl_reg_third}  :
                          {5'h00, match_flag_reg};
    assign compwin_view = (bank_sel == 2'h0) ? comp_rdata_a :
                          (bank_sel == 2'h1) ? comp_rdata_b :
                          (bank_sel == 2'h2) ? comp_rdata_c :
                          dat_pkg::READ_ZERO;
    assign read_mux     = hit_ctrl    ? ctrl_view    :
                          hit_status  ? status_view  :
                          hit_count   ? count_view   :
                          hit_seqwin  ? seqwin_view  :
                          hit_compwin ? compwin_view : dat_pkg::READ_ZERO;

    always_ff @(posedge clk) begin
        if (reset) begin
            reg_rdata <= dat_pkg::READ_ZERO;
        end else if (reg_read) begin
            reg_rdata <= read_mux;
        end else begin
            reg_rdata <= dat_pkg::READ_ZERO;
        end
    end

    // --------------------
    // Breakpoint routing
    // --------------------
    dat_break_route u_break_route (
        .clk                    (clk),
        .reset                  (reset),
        .brk_req                (brk_req),
        .background_debug_route (background_debug_route),
        .background_enable_bit  (background_enable_bit),
        .background_active      (background_active),
        .brk_background         (brk_background),
        .brk_software_interrupt (brk_software_interrupt)
    );

    // --------------------
    // Status outputs
    // --------------------
    assign comparator_bank_select = bank_sel;
    assign trace_enable           = trace_ok;
    assign trace_all_valid        = trace_full_flag;
    assign armed                  = arm;

endmodule // dat_debug_ctrl

`default_nettype wire

/* dat_debug_ctrl_chk.sv */
// Checker for the debug arm, trigger and status slice
`timescale 1ns/100ps
`default_nettype none

module dat_debug_ctrl_chk (
    // Clock and reset
    input wire logic       clk,
    input wire logic       reset,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_write,
    input wire logic       reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic [1:0] comparator_bank_select,
    input wire logic [2:0] comp_write,
    // Sequencer, trace and breakpoints
    input wire logic       seq_step,
    input wire logic [2:0] seq_state,
    input wire logic       armed,
    input wire logic       seq_enter_state1,
    input wire logic       seq_return_state0,
    input wire logic       trace_trigger,
    input wire logic       trace_enable,
    input wire logic       chip_secured,
    input wire logic       brk_background,
    input wire logic       brk_software_interrupt
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    wire win = reg_addr[7:3] == 5'h05;
    wire brk = brk_background || brk_software_interrupt;

    sequence s_final;
        armed && seq_step && seq_state == 3'h4;
    endsequence
    sequence s_arm_wr;
        reg_write && reg_addr == 8'h20 && !armed && reg_wdata[7] && !reg_wdata[6];
    endsequence

    property p_lock;
        armed && reg_write && win |-> comp_write == 3'h0;
    endproperty
    a_lock: assert property (p_lock) else $error("window write passed while armed");
    property p_window;
        !armed && reg_write && win |->
            comp_write == (comparator_bank_select == 2'h3 ? 3'h0 : 3'h1 << comparator_bank_select);
    endproperty
    a_window: assert property (p_window) else $error("wrong bank strobe");
    property p_force_trigger_zero;
        reg_read && reg_addr == 8'h20 |=> reg_rdata[6:5] == 2'h0;
    endproperty
    a_force_trigger_zero: assert property (p_force_trigger_zero) else $error("trigger bit read as one");
    property p_status;
        reg_read && reg_addr == 8'h21 |=> reg_rdata[6:3] == 4'h0 && reg_rdata[2:0] <= 3'h4;
    endproperty
    a_status: assert property (p_status) else $error("bad status layout");
    property p_arm;
        s_arm_wr |=> armed && seq_enter_state1 ##1 !seq_enter_state1;
    endproperty
    a_arm: assert property (p_arm) else $error("arming did not enter state1");
    property p_untraced;
        s_final ##0 !trace_enable |=> !armed && seq_return_state0;
    endproperty
    a_untraced: assert property (p_untraced) else $error("untraced end missing");
    property p_traced;
        s_final ##0 trace_enable |=> trace_trigger;
    endproperty
    a_traced: assert property (p_traced) else $error("trace trigger missing");
    property p_secure;
        chip_secured |-> !trace_enable;
    endproperty
    a_secure: assert property (p_secure) else $error("tracing while secured");
    property p_pulse;
        brk |=> !brk;
    endproperty
    a_pulse: assert property (p_pulse) else $error("breakpoint longer than one cycle");
    property p_quiet;
        !armed [*3] |-> !brk;
    endproperty
    a_quiet: assert property (p_quiet) else $error("breakpoint without session");
endmodule // dat_debug_ctrl_chk

bind dat_debug_ctrl dat_debug_ctrl_chk dat_debug_ctrl_chk_i (.clk, .reset, .reg_addr,
    .reg_wdata, .reg_write, .reg_read, .reg_rdata, .comparator_bank_select, .comp_write,
    .seq_step, .seq_state, .armed, .seq_enter_state1, .seq_return_state0, .trace_trigger,
    .trace_enable, .chip_secured, .brk_background, .brk_software_interrupt);
`default_nettype wire

/* dat_far_model.sv */
// Far-side model: state sequencer and trace buffer
`timescale 1ns/100ps
`default_nettype none

module dat_far_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // Bench commands
    input  wire logic       advance,
    input  wire logic       slow,
    input  wire logic [7:0] lines,
    // From the slice
    input  wire logic       seq_enter_state1,
    input  wire logic       trace_trigger,
    // To the slice
    output logic            seq_step,
    output logic      [2:0] seq_state,
    output logic            tracing_active,
    output logic            trace_session_done,
    output logic            trace_line_stored,
    output logic      [5:0] trace_line_count
);
    logic [2:0] st;
    logic [7:0] left;
    logic       tick;
    always_ff @(posedge clk) begin
        seq_step <= 1'b0;
        seq_state <= ~seq_state;
        trace_session_done <= 1'b0;
        trace_line_stored <= 1'b0;
        tick <= ~tick;
        if (reset) begin
            {st, seq_state, tracing_active, tick, left} <= '0;
            trace_line_count <= 6'h00;
        end else begin
            if (seq_enter_state1) begin
                st <= 3'h1;
                trace_line_count <= 6'h00;
            end
            if (advance && st != 3'h0 && st != 3'h4) begin
                st <= st + 3'h1;
                seq_step <= 1'b1;
                seq_state <= st + 3'h1;
            end
            if (trace_trigger) begin
                tracing_active <= 1'b1;
                left <= lines;
            end
            // Slow mode stores a line every other cycle
            if (tracing_active && (!slow || tick)) begin
                if (left != 8'h00) begin
                    left <= left - 8'h01;
                    trace_line_stored <= 1'b1;
                    trace_line_count <= trace_line_count + 6'h01;
                end else begin
                    tracing_active <= 1'b0;
                    trace_session_done <= 1'b1;
                end
            end
        end
    end
endmodule // dat_far_model
`default_nettype wire

/* dat_debug_ctrl_test.sv */
// Self-checking bench for the debug arm, trigger and status slice
`timescale 1ns/100ps
`default_nettype none

module dat_debug_ctrl_test;
    logic       clk, reset, por, reg_write, reg_read, advance, slow, seq_step, armed;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, lines, o;
    logic [7:0] cmp [4];
    logic [3:0] scr [4];
    logic [2:0] match_flag_reg, seq_state;
    logic [5:0] trace_line_count;
    logic       seq_enter_state1, seq_return_state0, trace_request, trigger_alignment;
    logic       tracing_active, trace_session_done, trace_line_stored, trace_trigger;
    logic       trace_enable, trace_all_valid, background_enable_bit, background_active;
    logic       chip_secured, brk_background, brk_software_interrupt;
    int         seed, compares, num_errors, cycles, n_bg, n_swi, n_tt;

    dat_debug_ctrl dat_debug_ctrl_i (.clk, .reset, .por, .reg_addr, .reg_wdata, .reg_write,
        .reg_read, .reg_rdata, .comparator_bank_select(), .comp_write(), .comp_offset(),
        .comp_wdata(), .comp_rdata_a(cmp[0]), .comp_rdata_b(cmp[1]), .comp_rdata_c(cmp[2]),
        .seq_ctrl_write(), .seq_ctrl_reg_first(scr[0]), .seq_ctrl_reg_second(scr[1]),
        .seq_ctrl_reg_third(scr[2]), .match_flag_reg, .seq_step, .seq_state,
        .seq_enter_state1, .seq_return_state0, .trace_request, .trigger_alignment,
        .tracing_active, .trace_session_done, .trace_line_stored, .trace_line_count,
        .trace_trigger, .trace_enable, .trace_all_valid, .background_enable_bit,
        .background_active, .chip_secured, .brk_background, .brk_software_interrupt, .armed);
    dat_far_model dat_far_model_i (.clk, .reset, .advance, .slow, .lines, .seq_enter_state1,
        .trace_trigger, .seq_step, .seq_state, .tracing_active, .trace_session_done,
        .trace_line_stored, .trace_line_count);

    // --------------------
    // Clock, pulse counters, timeout
    // --------------------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(negedge clk) begin
        n_bg += int'(brk_background);
        n_swi += int'(brk_software_interrupt);
        n_tt += int'(trace_trigger);
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            conclude();
        end
    end

    // --------------------
    // Tasks and expectations
    // --------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 chk(reg_rdata, e);
        @(posedge clk);
    endtask
    task automatic step;
        advance <= 1'b1;
        @(posedge clk);
        advance <= 1'b0;
        @(posedge clk);
    endtask
    task automatic settle;
        for (int i = 0; i < 600 && armed !== 1'b0; i++) @(posedge clk);
        repeat (4) @(posedge clk);
    endtask
    task automatic rnd;
        for (int i = 0; i < 3; i++) begin
            cmp[i] <= 8'($random(seed));
            scr[i] <= 4'($random(seed));
        end
        match_flag_reg <= 3'($random(seed));
        slow <= 1'($random(seed));
    endtask
    // Expected pulses {background, software interrupt}
    function automatic logic [1:0] route(input logic r, input logic e, input logic a);
        if (r && e) return 2'h2;
        if (r || !a) return 2'h1;
        return 2'h0;
    endfunction
    task automatic conclude;
        $display("compares=%0d num_errors=%0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // --------------------
    // Main sequence
    // --------------------
    initial begin
        seed = 34;
        {reset, por, reg_write, reg_read, advance, trigger_alignment} = 6'h30;
        {trace_request, background_enable_bit, background_active, chip_secured} = 4'h0;
        {reg_addr, reg_wdata, lines, cmp[3], scr[3]} = '0;
        rnd();
        repeat (12) @(posedge clk);
        {reset, por} <= 2'h0;
        @(posedge clk);
        rd(8'h20, 8'h00);
        wr(8'h21, 8'hFF);
        rd(8'h21, 8'h00);
        rd(8'h30, 8'h00);
        for (int s = 0; s < 4; s++) begin
            rnd();
            o = 8'($random(seed)) & 8'h07;
            wr(8'h20, 8'(s));
            rd(8'h27, s == 3 ? {5'h0, match_flag_reg} : {4'h0, scr[s]});
            rd(8'h28 | o, cmp[s]);
            wr(8'h28 | o, 8'h5A);
        end
        wr(8'h20, 8'h1B);
        rd(8'h20, 8'h1B);
        wr(8'h20, 8'h98);
        rd(8'h21, 8'h01);
        wr(8'h2A, 8'h55);
        wr(8'h20, 8'h02);
        rd(8'h20, 8'h1A);
        rd(8'h21, 8'h01);
        for (int k = 0; k < 8; k++) begin
            rnd();
            {background_enable_bit, background_active, trace_request} <= {k[1:0], k[0]};
            lines <= 8'h05;
            wr(8'h20, {3'h4, k[2], 4'h8});
            step();
            step();
            rd(8'h21, 8'h03);
            n_bg = 0;
            n_swi = 0;
            step();
            settle();
            rd(8'h21, 8'h00);
            chk(8'(n_bg * 2 + n_swi), {6'h0, route(k[2], k[1], k[0])});
        end
        {background_active, trace_request, lines} <= {2'h1, 8'd70};
        n_tt = 0;
        n_swi = 0;
        wr(8'h20, 8'hC8);
        settle();
        chk(8'(n_tt * 2 + n_swi), 8'h03);
        rd(8'h21, 8'h80);
        rd(8'h26, 8'h86);
        chk({7'h0, trace_all_valid}, 8'h01);
        reset <= 1'b1;
        @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        rd(8'h21, 8'h80);
        wr(8'h20, 8'h80);
        rd(8'h21, 8'h01);
        n_tt = 0;
        wr(8'h20, 8'hC0);
        rd(8'h21, 8'h01);
        chk(8'(n_tt * 2 + int'(armed)), 8'h00);
        for (int k = 0; k < 2; k++) begin
            {trace_request, chip_secured} <= {k[0], k[0]};
            n_tt = 0;
            n_swi = 0;
            wr(8'h20, 8'hC8);
            settle();
            chk(8'(n_tt * 2 + n_swi), 8'h01);
            rd(8'h21, 8'h00);
        end
        conclude();
    end
endmodule // dat_debug_ctrl_test
`default_nettype wire
